// ---- design/dads_exec.sv ----
// Execution unit for decimal adjust and decrement skip instructions
`timescale 1ns/1ps
`default_nettype none
`include "dads_defines.svh"
module dads_exec (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire dads_pkg::dads_req_t req,
  output var  dads_pkg::dads_rsp_t rsp
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dads_pkg::dads_top_state_t state;
  dads_pkg::dads_top_state_t next_state;
  logic [7:0] dec_value;
  logic [7:0] adj_value;
  logic       adj_carry;

  // ----------------------------------------------------------------
  // Decimal correction
  // ----------------------------------------------------------------
  dads_bcd_fix u_fix (
    .value         (req.accumulator),
    .carry_in      (req.carry),
    .half_carry_in (req.half_carry),
    .result        (adj_value),
    .carry_out     (adj_carry)
  );

  assign dec_value = req.reg_data - `DADS_BYTE_ONE;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_state.rsp = '0;
    case (state.st)
      dads_pkg::DADS_ST_SKIP:
      begin
        // Second cycle: fetched instruction replaced by a no-op
        next_state.st         = dads_pkg::DADS_ST_RUN;
        next_state.rsp.squash = 1'b1;
      end
      dads_pkg::DADS_ST_RUN:
      begin
        case (req.op)
          dads_pkg::DADS_OP_DECIMAL_ADJUST:
          begin
            next_state.rsp.acc_we   = 1'b1;
            next_state.rsp.acc_data = adj_value;
            next_state.rsp.carry_we = 1'b1;
            next_state.rsp.carry    = adj_carry;
          end
          dads_pkg::DADS_OP_DECREMENT_SKIP:
          begin
            if (req.dest == `DADS_DEST_ACC)
            begin
              next_state.rsp.acc_we   = 1'b1;
              next_state.rsp.acc_data = dec_value;
            end
            else
            begin
              next_state.rsp.reg_we   = 1'b1;
              next_state.rsp.reg_idx  = req.reg_idx;
              next_state.rsp.reg_data = dec_value;
            end
            next_state.rsp.zero_we = 1'b1;
            next_state.rsp.zero    = (dec_value == `DADS_BYTE_ZERO);
            if (dec_value == `DADS_BYTE_ZERO)
            begin
              next_state.st       = dads_pkg::DADS_ST_SKIP;
              next_state.rsp.busy = 1'b1;
            end
          end
          default:
          begin
            next_state.rsp = '0;
          end
        endcase
      end
      default:
      begin
        next_state.st = dads_pkg::DADS_ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rsp = state.rsp;
endmodule
`default_nettype wire

// ---- pkg/dads_defines.svh ----
// Constants for the decimal adjust and decrement skip datapath
`ifndef DADS_DEFINES_SVH
`define DADS_DEFINES_SVH
`define DADS_NIB_LIMIT   4'h9
`define DADS_NIB_FIX     4'h6
`define DADS_BYTE_ONE    8'h01
`define DADS_BYTE_ZERO   8'h00
`define DADS_DEST_ACC    1'b0
`define DADS_DEST_REG    1'b1
`define DADS_RIDX_MAX    6'h3F
`endif

// ---- pkg/dads_pkg.sv ----
// Types for the decimal adjust and decrement skip datapath
package dads_pkg;
  typedef enum logic [1:0] {
    DADS_OP_NONE,
    DADS_OP_DECIMAL_ADJUST,
    DADS_OP_DECREMENT_SKIP
  } dads_op_t;

  typedef struct packed {
    dads_op_t   op;
    logic       dest;
    logic [5:0] reg_idx;
    logic [7:0] reg_data;
    logic [7:0] accumulator;
    logic       carry;
    logic       half_carry;
  } dads_req_t;

  typedef struct packed {
    logic       acc_we;
    logic [7:0] acc_data;
    logic       reg_we;
    logic [5:0] reg_idx;
    logic [7:0] reg_data;
    logic       carry_we;
    logic       carry;
    logic       zero_we;
    logic       zero;
    logic       squash;
    logic       busy;
  } dads_rsp_t;

  typedef enum logic {
    DADS_ST_RUN,
    DADS_ST_SKIP
  } dads_state_t;

  typedef struct packed {
    dads_state_t st;
    dads_rsp_t   rsp;
  } dads_top_state_t;
endpackage

// ---- design/dads_bcd_fix.sv ----
// Packed decimal correction of one byte after a binary addition
`timescale 1ns/1ps
`default_nettype none
`include "dads_defines.svh"
module dads_bcd_fix (
  input  wire logic [7:0] value,
  input  wire logic       carry_in,
  input  wire logic       half_carry_in,
  output logic      [7:0] result,
  output logic            carry_out
);
  logic [4:0] low_sum;
  logic [4:0] high_sum;
  logic       low_fix;
  logic       high_fix;

  always_comb
  begin
    low_fix  = half_carry_in || (value[3:0] > `DADS_NIB_LIMIT);
    low_sum  = {1'b0, value[3:0]} + (low_fix ? {1'b0, `DADS_NIB_FIX} : 5'h00);
    high_fix = carry_in || (value[7:4] > `DADS_NIB_LIMIT)
      || ((value[7:4] == `DADS_NIB_LIMIT) && low_sum[4]);
    high_sum = {1'b0, value[7:4]} + {4'h0, low_sum[4]}
      + (high_fix ? {1'b0, `DADS_NIB_FIX} : 5'h00);
    result    = {high_sum[3:0], low_sum[3:0]};
    carry_out = carry_in || high_sum[4];
  end
endmodule
`default_nettype wire

// ---- sim/dads_exec_chk.sv ----
// Assertions on the decimal adjust and decrement skip datapath
`timescale 1ns/1ps
`default_nettype none
module dads_chk (
  input wire logic                clk,
  input wire logic                resetn,
  input wire dads_pkg::dads_req_t req,
  input wire dads_pkg::dads_rsp_t rsp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic da;
  logic dec;
  assign da = req.op == dads_pkg::DADS_OP_DECIMAL_ADJUST && !rsp.busy;
  assign dec = req.op == dads_pkg::DADS_OP_DECREMENT_SKIP && !rsp.busy;
  sequence s_skip; rsp.busy ##1 rsp.squash && !rsp.busy; endsequence
  property p_da; da |=> rsp.acc_we && rsp.carry_we; endproperty
  a_da: assert property (p_da) else $error("adjust write missing");
  property p_dst;
    dec |=> rsp.reg_we == $past(req.dest) && rsp.acc_we != rsp.reg_we;
  endproperty
  a_dst: assert property (p_dst) else $error("wrong target");
  property p_val;
    dec |=> (rsp.reg_we ? rsp.reg_data : rsp.acc_data)
            == $past(req.reg_data) - 8'h01;
  endproperty
  a_val: assert property (p_val) else $error("wrong decrement");
  property p_skip; dec && req.reg_data == 8'h01 |=> s_skip; endproperty
  a_skip: assert property (p_skip) else $error("no skip");
  property p_run;
    dec && req.reg_data != 8'h01 |=> !rsp.busy ##1 !rsp.squash;
  endproperty
  a_run: assert property (p_run) else $error("spurious skip");
  property p_cy; da && req.carry |=> rsp.carry; endproperty
  a_cy: assert property (p_cy) else $error("carry lost");
endmodule
bind dads_exec dads_chk chk (.clk(clk), .resetn(resetn), .req(req),
  .rsp(rsp));
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the decimal adjust and decrement skip datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                clk = 0;
  logic                resetn = 0;
  dads_pkg::dads_req_t req = '0;
  dads_pkg::dads_rsp_t rsp;
  dads_pkg::dads_rsp_t q[$];
  dads_pkg::dads_rsp_t exp_rsp;
  int                  n_mismatch = 0;
  int                  tests_run = 0;
  dads_exec dut (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp));
  always #50 clk = ~clk;
  task automatic wrap_up;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [29:0] key(dads_pkg::dads_rsp_t x);
    return {x.acc_we ? x.acc_data : 8'h00,
            x.reg_we ? {x.reg_idx, x.reg_data} : 14'h0000,
            x.carry_we & x.carry, x.zero_we & x.zero, x.acc_we, x.reg_we,
            x.carry_we, x.zero_we, x.squash, x.busy};
  endfunction
  task automatic compare_write(dads_pkg::dads_rsp_t got, exp);
    tests_run++;
    if (key(got) !== key(exp))
    begin
      n_mismatch++;
      $display("ERROR %0t unexpected write result", $time);
    end
  endtask
  task automatic compare_squash(dads_pkg::dads_rsp_t got, exp);
    tests_run++;
    if (key(got) !== key(exp))
    begin
      n_mismatch++;
      $display("ERROR %0t unexpected squash result", $time);
    end
  endtask
  task automatic run(dads_pkg::dads_op_t o, logic [7:0] a, r, logic d, c, h);
    dads_pkg::dads_rsp_t e;
    logic [8:0]          v;
    v = {1'b0, a};
    @(negedge clk);
    req = '{o, d, 6'($urandom), r, a, c, h};
    if (a[3:0] > 9 || h) v += 9'h006;
    if (v[8:4] > 9 || c) v += 9'h060;
    e = '{acc_we:1'b1, acc_data:v[7:0], carry_we:1'b1, carry:c | v[8],
          default:'0};
    if (o == dads_pkg::DADS_OP_DECREMENT_SKIP)
      e = '{zero_we:1'b1, zero:r == 8'h01, busy:r == 8'h01, acc_we:!d,
            reg_we:d, acc_data:r - 8'h01, reg_data:r - 8'h01,
            reg_idx:req.reg_idx, default:'0};
    q.push_back(e);
    if (e.busy)
    begin
      e = '{squash:1'b1, default:'0};
      q.push_back(e);
      @(negedge clk);
      req.op = dads_pkg::DADS_OP_NONE;
    end
  endtask
  always @(negedge clk)
    if (resetn && (rsp.acc_we | rsp.reg_we | rsp.zero_we | rsp.squash))
    begin
      exp_rsp = q.size() ? q.pop_front() : '1;
      if (exp_rsp.squash)
        compare_squash(rsp, exp_rsp);
      else
        compare_write(rsp, exp_rsp);
    end
  initial
  begin
    logic [7:0] x;
    logic [7:0] y;
    logic [8:0] s;
    void'($urandom(32'hEB18));
    repeat (20) @(negedge clk);
    resetn = 1;
    repeat (80)
    begin
      x = {4'($urandom % 10), 4'($urandom % 10)};
      y = {4'($urandom % 10), 4'($urandom % 10)};
      s = x + y;
      run(dads_pkg::DADS_OP_DECIMAL_ADJUST, s[7:0], x, 0, s[8],
          x[3:0] + y[3:0] > 15);
      run(dads_pkg::DADS_OP_DECREMENT_SKIP, y, x[0] ? x : 8'($urandom % 3),
          y[0], 0, 0);
    end
    @(negedge clk);
    req.op = dads_pkg::DADS_OP_NONE;
    repeat (4) @(negedge clk);
    if (q.size() != 0)
    begin
      n_mismatch++;
      $display("ERROR %0t results missing", $time);
    end
    wrap_up();
  end
  initial
  begin
    #(1000 * 100);
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
